/* File: core/ass_scan_sequencer.sv */
// Burst scan sequencer with queue address counter, queue RAM and counters.
// Assumes a classic Wishbone master and synchronous trigger input.
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Burst mode converts burst count plus one channels per pacer tick, burst count in hold mode.
// - With burst disabled, burst count and spacing are ignored.
// - Hold mode spends one extra pacer slot; software limits count to 255.
// - Conversions in a burst are spaced spacing plus one microsecond ticks.
// - Burst count, spacing and queue start reset to zero.
// - Writing queue start loads the queue address counter.
// - Queue address counter decrements after each entry load.
// - Software writes start, loads entries downward, then rewrites start.
// - Address decrements about 500 ns after each conversion start.
// - After the last queue entry the start address is reloaded.
// - Counter 0 counts samples after the about-trigger event.
// - About-trigger is first edge, or next edge when trigger enable set.
// - Counter 0 runs only in about-trigger mode after the event.
// - Counters 1 and 2 cascade; counter 2 paces conversions and interrupts.
// - Counter 0 terminal count sets a done flag and may interrupt.
module ass_scan_sequencer
  import ass_pkg::*;
#(
  parameter int QUEUE_DEPTH = 256,
  parameter int ENTRY_W = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic externalTriggerInput,
  output logic convertStart,
  output logic [ENTRY_W-1:0] channelGain,
  output logic holdSample,
  output logic pacerOut,
  output logic irq
);
  // ==========================================================================
  // Register bus decode.
  logic [7:0] scanLengthMinusOne_r;
  logic [5:0] spacingTicksMinusOne_r;
  logic [7:0] queueStartField_r;
  logic [7:0] control_r;
  logic [7:0] queueAddr_r;
  logic [15:0] cnt0Load_r;
  logic [15:0] cnt1Load_r;
  logic [15:0] cnt2Load_r;
  logic [2:0] irqStatus_r;
  logic [2:0] irqEnable_r;
  logic [31:0] readData;
  logic [7:0] regIdx;
  logic busReq;
  logic wrStrobe;
  logic lane0;
  logic lanes01;
  logic [ENTRY_W-1:0] channelGainQueueRam [QUEUE_DEPTH];
  assign regIdx = wb_adr_i[9:2];
  assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wrStrobe = busReq && wb_we_i;
  assign lane0 = wb_sel_i[0];
  assign lanes01 = wb_sel_i[0] && wb_sel_i[1];
  logic wrCount;
  logic wrSpacing;
  logic wrStart;
  logic wrControl;
  logic wrData;
  logic wrCnt0;
  logic wrCnt1;
  logic wrCnt2;
  logic wrEnable;
  logic wrClear;
  assign wrCount = wrStrobe && lane0 && regIdx == IDX_BURST_COUNT;
  assign wrSpacing = wrStrobe && lane0 && regIdx == IDX_BURST_SPACING;
  assign wrStart = wrStrobe && lane0 && regIdx == IDX_QUEUE_START;
  assign wrControl = wrStrobe && lane0 && regIdx == IDX_CONTROL;
  assign wrData = wrStrobe && lanes01 && regIdx == IDX_QUEUE_DATA;
  assign wrCnt0 = wrStrobe && lanes01 && regIdx == IDX_CNT0;
  assign wrCnt1 = wrStrobe && lanes01 && regIdx == IDX_CNT1;
  assign wrCnt2 = wrStrobe && lanes01 && regIdx == IDX_CNT2;
  assign wrEnable = wrStrobe && lane0 && regIdx == IDX_IRQ_ENABLE;
  assign wrClear = wrStrobe && lane0 && regIdx == IDX_IRQ_CLEAR;
  // Unmapped addresses and the write-only clear register read as zero.
  assign readData =
      (regIdx == IDX_BURST_COUNT) ? {24'h00_0000, scanLengthMinusOne_r} :
      (regIdx == IDX_BURST_SPACING) ? {26'h000_0000, spacingTicksMinusOne_r} :
      (regIdx == IDX_QUEUE_START) ? {24'h00_0000, queueStartField_r} :
      (regIdx == IDX_CONTROL) ? {24'h00_0000, control_r} :
      (regIdx == IDX_QUEUE_DATA) ? {16'h0000, 16'(channelGainQueueRam[queueAddr_r])} :
      (regIdx == IDX_QUEUE_ADDR) ? {24'h00_0000, queueAddr_r} :
      (regIdx == IDX_CNT0) ? {16'h0000, cnt0Load_r} :
      (regIdx == IDX_CNT1) ? {16'h0000, cnt1Load_r} :
      (regIdx == IDX_CNT2) ? {16'h0000, cnt2Load_r} :
      (regIdx == IDX_IRQ_STATUS) ? {29'h0000_0000, irqStatus_r} :
      (regIdx == IDX_IRQ_ENABLE) ? {29'h0000_0000, irqEnable_r} :
      32'h0000_0000;
  // Every access answers one cycle after the strobe, ack drops the next cycle.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= busReq;
      wb_dat_o <= busReq ? readData : 32'h0000_0000;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      scanLengthMinusOne_r <= RST_BYTE;
      spacingTicksMinusOne_r <= 6'h00;
      queueStartField_r <= RST_BYTE;
      control_r <= RST_BYTE;
      cnt0Load_r <= RST_WORD;
      cnt1Load_r <= RST_WORD;
      cnt2Load_r <= RST_WORD;
      irqEnable_r <= 3'h0;
    end else begin
      if (wrCount) scanLengthMinusOne_r <= wb_dat_i[7:0];
      if (wrSpacing) spacingTicksMinusOne_r <= wb_dat_i[5:0] & SPACING_MASK_W;
      if (wrStart) queueStartField_r <= wb_dat_i[7:0];
      if (wrControl) control_r <= wb_dat_i[7:0];
      if (wrCnt0) cnt0Load_r <= wb_dat_i[15:0];
      if (wrCnt1) cnt1Load_r <= wb_dat_i[15:0];
      if (wrCnt2) cnt2Load_r <= wb_dat_i[15:0];
      if (wrEnable) irqEnable_r <= wb_dat_i[2:0];
    end
  end
  logic runEnable;
  logic burstEnableBit;
  logic simultaneousHoldMode;
  logic aboutTriggerEnable;
  logic externalTriggerEnable;
  logic gateActive;
  assign runEnable = control_r[CTL_RUN];
  assign burstEnableBit = control_r[CTL_BURST];
  assign simultaneousHoldMode = control_r[CTL_HOLD];
  assign aboutTriggerEnable = control_r[CTL_ABOUT];
  assign externalTriggerEnable = control_r[CTL_TRIG_EN];
  // Pacer runs only while gate enable or gate select is set, so loads happen idle.
  assign gateActive = control_r[CTL_GATE_EN] || control_r[CTL_GATE_SEL];
  // ==========================================================================
  // Tick dividers: 1 us burst tick and 5 MHz counter source.
  logic [4:0] usDiv_r;
  logic [2:0] srcDiv_r;
  logic usTick;
  logic srcTick;
  assign usTick = (usDiv_r == 5'(BURST_DIV - 1));
  assign srcTick = (srcDiv_r == 3'(SRC_DIV - 1));
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      usDiv_r <= 5'h00;
      srcDiv_r <= 3'h0;
    end else begin
      usDiv_r <= usTick ? 5'h00 : usDiv_r + 5'h01;
      srcDiv_r <= srcTick ? 3'h0 : srcDiv_r + 3'h1;
    end
  end
  // ==========================================================================
  // Cascaded pacer counters and the post-trigger counter.
  logic cnt1Tc;
  logic pacerTick;
  logic cnt0Tc;
  logic aboutEvent_r;
  logic armed_r;
  logic trigPrev_r;
  logic trigEdge;
  assign trigEdge = control_r[CTL_TRIG_POL] ? (externalTriggerInput && !trigPrev_r)
                                            : (!externalTriggerInput && trigPrev_r);
  ass_down_counter #(.WIDTH(16)) u_cnt1 (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(wrCnt1),
    .loadValue(wb_dat_i[15:0]),
    .tick(srcTick && gateActive),
    .reload(1'b1),
    .terminal(cnt1Tc)
  );
  ass_down_counter #(.WIDTH(16)) u_cnt2 (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(wrCnt2),
    .loadValue(wb_dat_i[15:0]),
    .tick(cnt1Tc),
    .reload(1'b1),
    .terminal(pacerTick)
  );
  ass_down_counter #(.WIDTH(16)) u_cnt0 (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(wrCnt0),
    .loadValue(wb_dat_i[15:0]),
    .tick(convertStart && aboutTriggerEnable && aboutEvent_r),
    .reload(1'b0),
    .terminal(cnt0Tc)
  );
  // The first active edge counts, or with trigger enable the next edge after the start edge.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      trigPrev_r <= 1'b0;
      aboutEvent_r <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      trigPrev_r <= externalTriggerInput;
      if (wrControl || wrCnt0) begin
        aboutEvent_r <= 1'b0;
        armed_r <= 1'b0;
      end else if (trigEdge && aboutTriggerEnable) begin
        if (!externalTriggerEnable || armed_r) aboutEvent_r <= 1'b1;
        armed_r <= 1'b1;
      end
    end
  end
  // ==========================================================================
  // Burst sequencing.
  logic [8:0] burstLeft_r;
  logic [6:0] spaceCnt_r;
  logic [4:0] advCnt_r;
  logic advPending_r;
  logic burstBusy;
  logic startConv;
  logic [8:0] burstTotal;
  assign burstBusy = (burstLeft_r != 9'h000);
  // Hold mode counts the software value as-is, giving one extra slot.
  assign burstTotal = simultaneousHoldMode ? {1'b0, scanLengthMinusOne_r}
                                           : {1'b0, scanLengthMinusOne_r} + 9'h001;
  // With bursts off and run set, every pacer tick starts exactly one conversion.
  assign startConv = runEnable && (burstEnableBit
      ? (burstBusy && spaceCnt_r == 7'h00 && usTick)
      : pacerTick);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      burstLeft_r <= 9'h000;
      spaceCnt_r <= 7'h00;
    end else if (!runEnable || !burstEnableBit) begin
      burstLeft_r <= 9'h000;
      spaceCnt_r <= 7'h00;
    end else if (pacerTick && !burstBusy) begin
      burstLeft_r <= burstTotal;
      spaceCnt_r <= 7'h00;
    end else if (startConv) begin
      burstLeft_r <= burstLeft_r - 9'h001;
      spaceCnt_r <= {1'b0, spacingTicksMinusOne_r};
    end else if (usTick && spaceCnt_r != 7'h00) begin
      spaceCnt_r <= spaceCnt_r - 7'h01;
    end
  end
  // ==========================================================================
  // Queue address counter and queue RAM.
  logic advanceNow;
  assign advanceNow = advPending_r && advCnt_r == 5'(ADVANCE_CYC - 1);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      advPending_r <= 1'b0;
      advCnt_r <= 5'h00;
    end else if (startConv) begin
      advPending_r <= 1'b1;
      advCnt_r <= 5'h00;
    end else if (advPending_r) begin
      advPending_r <= !advanceNow;
      advCnt_r <= advCnt_r + 5'h01;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (wrData) channelGainQueueRam[queueAddr_r] <= wb_dat_i[ENTRY_W-1:0];
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      queueAddr_r <= RST_BYTE;
    end else if (wrStart) begin
      queueAddr_r <= wb_dat_i[7:0];
    end else if (wrData) begin
      queueAddr_r <= queueAddr_r - 8'h01;
    end else if (advanceNow) begin
      // Reload at entry zero keeps the sequence cycling.
      queueAddr_r <= (queueAddr_r == 8'h00) ? queueStartField_r : queueAddr_r - 8'h01;
    end
  end
  // ==========================================================================
  // Interrupt status: set wins over a simultaneous clear.
  logic [2:0] irqEvents;
  assign irqEvents = {advanceNow && queueAddr_r == 8'h00, pacerTick, cnt0Tc};
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irqStatus_r <= 3'h0;
      irq <= 1'b0;
    end else begin
      irqStatus_r <= (irqStatus_r & ~(wrClear ? wb_dat_i[2:0] : 3'h0)) | irqEvents;
      irq <= |(irqStatus_r & irqEnable_r);
    end
  end
  // ==========================================================================
  // Converter-facing outputs, all registered.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      convertStart <= 1'b0;
      channelGain <= '0;
      holdSample <= 1'b0;
      pacerOut <= 1'b0;
    end else begin
      convertStart <= startConv;
      channelGain <= channelGainQueueRam[queueAddr_r];
      holdSample <= simultaneousHoldMode && pacerTick;
      pacerOut <= pacerTick;
    end
  end
endmodule : ass_scan_sequencer
`default_nettype wire

/* File: core/ass_pkg.sv */
// Constants shared by the scan sequencer and its counter module.
// Assumes a single 25 MHz system clock and a classic Wishbone register bus.
package ass_pkg;
  // ==========================================================================
  // Clock rates and derived tick periods.
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned BURST_TICK_HZ = 1000000;
  localparam int unsigned CNT_SRC_HZ = 5000000;
  localparam int unsigned BURST_DIV = CLK_HZ / BURST_TICK_HZ;
  localparam int unsigned SRC_DIV = CLK_HZ / CNT_SRC_HZ;
  localparam int unsigned ADVANCE_NS = 500;
  localparam int unsigned CLK_NS = 40;
  localparam int unsigned ADVANCE_CYC = (ADVANCE_NS + CLK_NS - 1) / CLK_NS;
  // ==========================================================================
  // Register indices; byte address is four times the index.
  localparam logic [7:0] IDX_BURST_COUNT = 8'h08;
  localparam logic [7:0] IDX_BURST_SPACING = 8'h09;
  localparam logic [7:0] IDX_QUEUE_START = 8'h0a;
  localparam logic [7:0] IDX_CONTROL = 8'h10;
  localparam logic [7:0] IDX_QUEUE_DATA = 8'h11;
  localparam logic [7:0] IDX_QUEUE_ADDR = 8'h12;
  localparam logic [7:0] IDX_CNT0 = 8'h13;
  localparam logic [7:0] IDX_CNT1 = 8'h14;
  localparam logic [7:0] IDX_CNT2 = 8'h15;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h18;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h19;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'h1a;
  // ==========================================================================
  // Control register bit positions.
  localparam int unsigned CTL_RUN = 0;
  localparam int unsigned CTL_BURST = 1;
  localparam int unsigned CTL_HOLD = 2;
  localparam int unsigned CTL_ABOUT = 3;
  localparam int unsigned CTL_TRIG_EN = 4;
  localparam int unsigned CTL_TRIG_POL = 5;
  localparam int unsigned CTL_GATE_SEL = 6;
  localparam int unsigned CTL_GATE_EN = 7;
  // Interrupt status bit positions.
  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IRQ_PACER = 1;
  localparam int unsigned IRQ_WRAP = 2;
  // ==========================================================================
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [5:0] SPACING_MASK_W = 6'h3f;
endpackage : ass_pkg

/* File: core/ass_down_counter.sv */
// Down counter, one-shot for the post-trigger counter and reloading for the pacer counters.
// Assumes its enable is a one-cycle tick on the system clock.
`timescale 1ns/1ps
`default_nettype none
module ass_down_counter
  import ass_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic load,
  input wire logic [WIDTH-1:0] loadValue,
  input wire logic tick,
  input wire logic reload,
  output logic terminal
);
  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] preset_r;
  logic atOne;
  assign atOne = (count_r == WIDTH'(1));
  // A reload counter restarts from its preset at one; a one-shot parks at zero.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      count_r <= '0;
      preset_r <= '0;
      terminal <= 1'b0;
    end else if (load) begin
      count_r <= loadValue;
      preset_r <= loadValue;
      terminal <= 1'b0;
    end else begin
      terminal <= tick && atOne;
      if (tick && count_r != '0) begin
        count_r <= (atOne && reload) ? preset_r : count_r - WIDTH'(1);
      end
    end
  end
endmodule : ass_down_counter
`default_nettype wire

/* File: verification/ass_scan_props.sv */
// Port checker for the scan sequencer, bound into the design module.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module ass_scan_props
  import ass_pkg::*;
#(
  parameter int ENTRY_W = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic externalTriggerInput,
  input wire logic convertStart,
  input wire logic [ENTRY_W-1:0] channelGain,
  input wire logic holdSample,
  input wire logic pacerOut,
  input wire logic irq
);
  // ==========================================================================
  // Helper logic.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire req = wb_cyc_i && wb_stb_i;
  wire rdAck = wb_ack_o && !wb_we_i;
  logic [2:0] wrAge_r;
  // Ages since the last write, so a falling irq can be traced to a host access.
  always_ff @(posedge clk_sys) begin
    if (rst || (req && wb_we_i)) begin
      wrAge_r <= 3'h0;
    end else if (wrAge_r != 3'h7) begin
      wrAge_r <= wrAge_r + 3'h1;
    end
  end
  // ==========================================================================
  // Properties.
  a_ack_follows_req: assert property (req && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(req))
    else $error("ack without request");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside ack");
  a_unmapped_zero: assert property (rdAck && wb_adr_i[9:2] == 8'h30 |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_spacing_top_zero: assert property (rdAck && wb_adr_i[9:2] == IDX_BURST_SPACING |-> wb_dat_o[31:6] == '0)
    else $error("spacing upper bits not zero");
  a_reset_quiet: assert property ($fell(rst) |-> !(irq || convertStart || pacerOut || holdSample || wb_ack_o))
    else $error("output active after reset");
  a_conv_gap: assert property (convertStart |=> !convertStart [*8])
    else $error("conversions too close");
  a_pacer_gap: assert property (pacerOut |=> !pacerOut [*8])
    else $error("pacer ticks too close");
  a_irq_fall_cause: assert property ($fell(irq) |-> wrAge_r <= 3'h4)
    else $error("irq fell with no host write");
  c_hold_seen: cover property (holdSample);
endmodule : ass_scan_props
bind ass_scan_sequencer ass_scan_props #(.ENTRY_W(ENTRY_W)) props (.clk_sys(clk_sys), .rst(rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .externalTriggerInput(externalTriggerInput),
  .convertStart(convertStart), .channelGain(channelGain), .holdSample(holdSample), .pacerOut(pacerOut),
  .irq(irq));
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench for the scan sequencer with a small queue model.
// Assumes the package register map and a 25 MHz system clock.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ass_pkg::*;
  // ==========================================================================
  // Signals and design.
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [2:0] busCtl = 3'h0;
  logic [9:0] adr = 10'h000;
  logic [31:0] datIn = 32'h0000_0000;
  logic trig = 1'b0;
  logic [31:0] datOut;
  logic ack, conv, hold, pacer, irq;
  logic [15:0] gain;
  logic [15:0] qm [256];
  logic [15:0] convG[$];
  int convT[$], pacT[$], holdT[$];
  int cycleNo = 0;
  int badCount = 0;
  int checksDone = 0;
  int seed = 32'h0000_bcbd;
  localparam logic [31:0] GO = (32'h0000_0001 << CTL_RUN) | (32'h0000_0001 << CTL_GATE_EN);
  localparam logic [31:0] DONE = 32'h0000_0001 << IRQ_DONE;
  always #20 clk_sys = ~clk_sys;
  ass_scan_sequencer uut (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(busCtl[2]), .wb_stb_i(busCtl[1]),
    .wb_we_i(busCtl[0]), .wb_adr_i(adr), .wb_dat_i(datIn), .wb_sel_i(4'hf), .wb_dat_o(datOut),
    .wb_ack_o(ack), .externalTriggerInput(trig), .convertStart(conv), .channelGain(gain),
    .holdSample(hold), .pacerOut(pacer), .irq(irq));
  always @(posedge clk_sys) begin
    cycleNo <= cycleNo + 1;
    if (conv === 1'b1) begin
      convT.push_back(cycleNo);
      convG.push_back(gain);
    end
    if (pacer === 1'b1) pacT.push_back(cycleNo);
    if (hold === 1'b1) holdT.push_back(cycleNo);
  end
  // ==========================================================================
  // Bus, waiting and comparison tasks.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      badCount++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Waits for ack with no cycle limit; only the watchdog ends a hung access.
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d, output logic [31:0] q);
    busCtl <= {2'b11, w};
    adr <= {idx, 2'b00};
    datIn <= d;
    @(posedge clk_sys);
    while (ack !== 1'b1) begin
      @(posedge clk_sys);
    end
    q = datOut;
    busCtl <= 3'h0;
    @(posedge clk_sys);
  endtask : xfer
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, idx, d, q);
  endtask : wr
  task automatic rdChk(input logic [7:0] idx, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] q;
    xfer(1'b0, idx, 32'h0000_0000, q);
    chk(q & m, exp);
  endtask : rdChk
  task automatic waitLen(ref int q[$], input int k);
    while (q.size() < k) @(posedge clk_sys);
  endtask : waitLen
  // Entries are sorted by time, so counts over a span come from two prefixes.
  function automatic int upTo(ref int q[$], input int x);
    int c;
    c = 0;
    foreach (q[i]) if (q[i] <= x) c++;
    return c;
  endfunction : upTo
  task automatic pace(input logic [31:0] c1, input logic [31:0] c2, input logic [31:0] ctl);
    wr(IDX_CONTROL, 32'h0000_0000);
    wr(IDX_CNT1, c1);
    wr(IDX_CNT2, c2);
    convT.delete();
    convG.delete();
    pacT.delete();
    holdT.delete();
    wr(IDX_CONTROL, ctl);
  endtask : pace
  task automatic burst(input logic h, input int cnt, input int sp);
    int f;
    wr(IDX_BURST_COUNT, 32'(cnt));
    wr(IDX_BURST_SPACING, 32'(sp));
    pace(32'h0000_0014, 32'h0000_000a, GO | (32'h0000_0001 << CTL_BURST) | (32'(h) << CTL_HOLD));
    waitLen(pacT, 3);
    f = upTo(convT, pacT[1]);
    chk(upTo(convT, pacT[2]) - f, h ? cnt : cnt + 1);
    chk(upTo(holdT, pacT[2] - 3) - upTo(holdT, pacT[1] - 3), 32'(h));
    if (cnt > 1) chk(convT[f + 1] - convT[f], (sp + 1) * BURST_DIV);
    $display("test burst hold=%0d count=%0d spacing=%0d done", h, cnt, sp);
  endtask : burst
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (60000) @(posedge clk_sys);
    badCount++;
    tally_and_finish();
  end
  // ==========================================================================
  // Main sequence.
  initial begin
    logic [31:0] v;
    int k;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rdChk(IDX_BURST_COUNT, 32'h0000_0000, 32'hffff_ffff);
    rdChk(IDX_BURST_SPACING, 32'h0000_0000, 32'hffff_ffff);
    rdChk(IDX_QUEUE_START, 32'h0000_0000, 32'hffff_ffff);
    rdChk(8'h30, 32'h0000_0000, 32'hffff_ffff);
    v = $random(seed);
    wr(IDX_BURST_SPACING, v);
    rdChk(IDX_BURST_SPACING, {26'h0, v[5:0]}, 32'hffff_ffff);
    $display("test registers done");
    wr(IDX_QUEUE_START, 32'h0000_0003);
    rdChk(IDX_QUEUE_ADDR, 32'h0000_0003, 32'h0000_00ff);
    for (k = 3; k >= 0; k--) begin
      qm[k] = {4'(k), 12'($random(seed))};
      wr(IDX_QUEUE_DATA, {16'h0000, qm[k]});
      if (k > 0) rdChk(IDX_QUEUE_ADDR, 32'(k - 1), 32'h0000_00ff);
    end
    wr(IDX_QUEUE_START, 32'h0000_0003);
    repeat (2) @(posedge clk_sys);
    chk({16'h0000, gain}, {16'h0000, qm[3]});
    $display("test queue done");
    wr(IDX_BURST_COUNT, 32'h0000_0005);
    pace(32'h0000_0002, 32'h0000_0003, GO);
    waitLen(pacT, 4);
    chk(pacT[2] - pacT[1], 2 * 3 * SRC_DIV);
    chk(upTo(convT, pacT[2]) - upTo(convT, pacT[1]), 1);
    for (k = 0; k < 3; k++) chk({16'h0000, convG[k]}, {16'h0000, qm[3 - k]});
    waitLen(convT, 6);
    for (k = 3; k < 6; k++) chk({16'h0000, convG[k]}, {16'h0000, qm[(7 - k) % 4]});
    k = 0;
    while (gain === convG[5] && k < 30) begin
      k++;
      @(posedge clk_sys);
    end
    chk(k >= 9 && k <= 15, 1);
    $display("test pacer done");
    burst(1'b0, 0, 2);
    burst(1'b0, 1 + ($unsigned($random(seed)) % 4), 2 + ($unsigned($random(seed)) % 3));
    burst(1'b1, 2 + ($unsigned($random(seed)) % 3), 2 + ($unsigned($random(seed)) % 3));
    wr(IDX_IRQ_ENABLE, DONE);
    wr(IDX_CNT0, 32'h0000_0002);
    pace(32'h0000_0002, 32'h0000_0003, GO | (32'h0000_0001 << CTL_ABOUT) | (32'h0000_0001 << CTL_TRIG_POL));
    waitLen(convT, 4);
    rdChk(IDX_IRQ_STATUS, 32'h0000_0000, DONE);
    chk(irq, 1'b0);
    trig <= 1'b1;
    waitLen(convT, 5);
    rdChk(IDX_IRQ_STATUS, 32'h0000_0000, DONE);
    waitLen(convT, 6);
    repeat (3) @(posedge clk_sys);
    rdChk(IDX_IRQ_STATUS, DONE, DONE);
    chk(irq, 1'b1);
    wr(IDX_IRQ_ENABLE, 32'h0000_0000);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b0);
    wr(IDX_IRQ_ENABLE, DONE);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b1);
    wr(IDX_IRQ_CLEAR, DONE);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b0);
    rdChk(IDX_IRQ_STATUS, 32'h0000_0000, DONE);
    $display("test about trigger done");
    wr(IDX_CONTROL, 32'h0000_0000);
    wr(IDX_QUEUE_START, 32'h0000_0000);
    qm[0] = 16'(($random(seed)));
    wr(IDX_QUEUE_DATA, {16'h0000, qm[0]});
    wr(IDX_QUEUE_START, 32'h0000_0000);
    repeat (2) @(posedge clk_sys);
    chk({16'h0000, gain}, {16'h0000, qm[0]});
    $display("test single channel done");
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
